// >>> design/amp_regs_defines.vh
// register layout, reset values and timing counts for the amplifier register bank
// included by the bank only, the two-wire slave uses none of it; definitions only
`ifndef AMP_REGS_DEFINES_VH
`define AMP_REGS_DEFINES_VH

// byte positions within a burst
`define IDX_R_BRIDGED 3'd0
`define IDX_L_BRIDGED 3'd1
`define IDX_R_ONE_ENDED 3'd2
`define IDX_L_ONE_ENDED 3'd3
`define IDX_MASK 3'd4
`define IDX_CTRL 3'd5
`define REG_COUNT 3'd6
`define LAST_IDX 3'd5

// reset values
`define GAIN_RESET 8'h3F
`define MASK_RESET 8'hFF
`define CTRL_RESET 8'h00

// gain register fields
`define GAIN_CODE_MSB 5
`define GAIN_MUTE_A 6
`define GAIN_MUTE_B 7

// mask register fields
`define MASK_PWRDN 0
`define MASK_MODE 1
`define MASK_TONE 2
`define MASK_BUSY 7

// control register fields
`define CTRL_PWRDN 0
`define CTRL_INPUT 1
`define CTRL_RSVD0 2
`define CTRL_MUTE 3
`define CTRL_RSVD1 4
`define CTRL_MODE 5
`define CTRL_GSEL 6
`define CTRL_TONE 7

// power-up sequence length in microseconds, and cycles at 100 MHz
`define PWRUP_US 100
`define CLK_MHZ 100
`define PWRUP_CYCLES (`PWRUP_US * `CLK_MHZ)

// tone detector: rising edges needed, and idle time that drops detection
`define TONE_EDGES 4'd8
`define TONE_IDLE_US 10000
`define TONE_IDLE_CYCLES (`TONE_IDLE_US * `CLK_MHZ)

// fixed upper five address bits, arbitrary default
`define ADDR_FIXED 5'h1B

`endif

// >>> design/two_wire_slave.v
// two-wire serial slave: start/stop, address match, byte shifting, ack
// assumes scl and sda inputs are already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave (
   input wire clk,
   input wire rst_n,
   input wire scl_s,
   input wire sda_s,
   input wire [6:0] own_addr,
   input wire [7:0] tx_byte,
   output reg sda_oe_n,
   output reg rx_valid,
   output reg [7:0] rx_byte,
   output reg tx_load,
   output reg frame_start,
   output reg is_read
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_ADDR = 5'b00010;
   localparam ST_WDATA = 5'b00100;
   localparam ST_RDATA = 5'b01000;
   localparam ST_ACK = 5'b10000;

   reg scl_q;
   reg sda_q;
   reg [4:0] state_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   reg master_nack_q;
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_c = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

   // bus state machine, driven by scl edges seen on clk
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         master_nack_q <= 1'b0;
         sda_oe_n <= 1'b1;
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
         tx_load <= 1'b0;
         frame_start <= 1'b0;
         is_read <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         rx_valid <= 1'b0;
         tx_load <= 1'b0;
         frame_start <= 1'b0;
         if (start_c) begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            state_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               ST_ADDR, ST_WDATA: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_q <= bit_q + 4'h1;
                  end
                  if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (state_q == ST_ADDR) begin
                        // address match: upper five fixed, two from pins
                        if (shift_q[7:1] == own_addr) begin
                           sda_oe_n <= 1'b0;
                           is_read <= shift_q[0];
                           frame_start <= 1'b1;
                           state_q <= ST_ACK;
                        end else begin
                           state_q <= ST_IDLE;
                        end
                     end else begin
                        rx_byte <= shift_q;
                        rx_valid <= 1'b1;
                        sda_oe_n <= 1'b0;
                        state_q <= ST_ACK;
                     end
                  end
               end
               ST_ACK: begin
                  // slave ack ends at the falling edge of the ninth clock
                  if (scl_fall) begin
                     if (is_read) begin
                        tx_load <= 1'b1;
                        shift_q <= tx_byte;
                        sda_oe_n <= tx_byte[7];
                        bit_q <= 4'h1;
                        state_q <= ST_RDATA;
                     end else begin
                        sda_oe_n <= 1'b1;
                        state_q <= ST_WDATA;
                     end
                  end
               end
               ST_RDATA: begin
                  if (scl_rise && bit_q == 4'h9) begin
                     master_nack_q <= sda_s;
                  end
                  if (scl_fall) begin
                     if (bit_q == 4'h8) begin
                        sda_oe_n <= 1'b1; // release for master ack
                        bit_q <= 4'h9;
                     end else if (bit_q == 4'h9) begin
                        if (master_nack_q) begin
                           state_q <= ST_IDLE;
                        end else begin
                           tx_load <= 1'b1;
                           shift_q <= tx_byte;
                           sda_oe_n <= tx_byte[7];
                           bit_q <= 4'h1;
                        end
                     end else begin
                        sda_oe_n <= shift_q[7 - bit_q[2:0]];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule // two_wire_slave
`default_nettype wire

// >>> design/amp_register_bank.v
// register bank of a stereo amplifier, reached over a two-wire serial slave
// assumes pins are asynchronous to SYS_CLK_I; power-up reset on RESETN_I
// outputs are registered and drive the analog controls directly
//
// What this block does
// - read burst returns all six registers
// - six-bit gain code, 64 steps
// - gain bit 7 or 6 mutes channel
// - power-up gain is minimum, minus sixty
// - mask bit 7 flags power-up running
// - mask bits choose pin or register control
// - mask one: external pin decides
// - mask zero: control bit decides; for tone, detection also enables
// - tone mask one gives automatic detection
// - control bit 0 high requests power-down
// - control bit 1 picks line or headphone
// - masked mode: input follows mode pin
// - control bit 3 mutes amplifier
// - control bit 5 picks output mode
// - control bit 6 picks gain set
// - masked mode: gain set follows pin
// - control bit 7 forces tone active
// - seven-bit address, two from pins
// - power-down mutes and enters low current
// - tone valid after eight rising edges
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs_defines.vh"
module amp_register_bank #(
   parameter [4:0] ADDR_FIXED = `ADDR_FIXED, // arbitrary default
   parameter [31:0] PWRUP_CYCLES = `PWRUP_CYCLES,
   parameter [31:0] TONE_IDLE_CYCLES = `TONE_IDLE_CYCLES
) (
   input wire SYS_CLK_I,
   input wire RESETN_I,
   input wire SCL_I,
   input wire SDA_I,
   output wire SDA_O,
   output wire SDA_OE_N_O,
   input wire ADDR_PIN_ONE_I,
   input wire ADDR_PIN_ZERO_I,
   input wire PWRDN_N_PIN_I,
   input wire OUTPUT_MODE_PIN_I,
   input wire TONE_INPUT_I,
   output reg [5:0] RIGHT_GAIN_CODE_O,
   output reg [5:0] LEFT_GAIN_CODE_O,
   output reg [6:0] RIGHT_ATTEN_STEP_O,
   output reg [6:0] LEFT_ATTEN_STEP_O,
   output reg RIGHT_MUTE_O,
   output reg LEFT_MUTE_O,
   output reg POWER_DOWN_O,
   output reg ONE_ENDED_OUTPUT_O,
   output reg INPUT_CHOICE_BIT_O,
   output reg TONE_ACTIVE_O,
   output reg POWERING_UP_O
);
   // two-flop synchronisers for every pin input
   // scl and sda share one delay, so start and stop keep their order
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         // idle levels: bus lines high, mode and tone low, no false edge
         sync1_q <= 7'h7C;
         sync2_q <= 7'h7C;
      end else begin
         sync1_q <= {SCL_I, SDA_I, ADDR_PIN_ONE_I, ADDR_PIN_ZERO_I, PWRDN_N_PIN_I,
            OUTPUT_MODE_PIN_I, TONE_INPUT_I};
         sync2_q <= sync1_q;
      end
   end
   wire scl_s = sync2_q[6];
   wire sda_s = sync2_q[5];
   wire a1_s = sync2_q[4];
   wire a0_s = sync2_q[3];
   wire pwrdn_n_s = sync2_q[2];
   wire mode_pin_s = sync2_q[1];
   wire tone_s = sync2_q[0];

   // monotonic code to attenuation step: code 3F is least gain
   // identity table; a reversed step order also changes the step reset values below
   function [6:0] gain_step;
      input [5:0] code;
      begin
         gain_step = {1'b0, code}; // one step of 1.25 dB per code
      end
   endfunction

   // mute when either mute bit of a gain byte is set
   // both mute bits act alike
   function gain_muted;
      input [7:0] g;
      begin
         gain_muted = g[`GAIN_MUTE_A] | g[`GAIN_MUTE_B];
      end
   endfunction

   // register storage, indexed by burst position
   // mask bit 7 is stored as written but never shown
   // the read path shows the live flag there instead
   reg [7:0] regs_q [0:5];
   reg [2:0] idx_q;
   reg busy_q;
   reg [31:0] pwrup_cnt_q;

   wire rx_valid;
   wire [7:0] rx_byte;
   wire tx_load;
   wire frame_start;
   wire is_read;
   wire slave_oe_n;
   // address pins are read live; change them only on an idle bus
   wire [6:0] own_addr = {ADDR_FIXED, a1_s, a0_s};

   // read byte: mask bit 7 shows the power-up flag
   // the slave copies this byte in the cycle it raises tx_load
   wire [7:0] tx_byte = (idx_q == `IDX_MASK) ?
      {busy_q, regs_q[`IDX_MASK][6:0]} : regs_q[idx_q];

   // bit-level bus engine; it sees only synchronised lines
   // address match and ack timing live there
   two_wire_slave u_slave (
      .clk(SYS_CLK_I),
      .rst_n(RESETN_I),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .own_addr(own_addr),
      .tx_byte(tx_byte),
      .sda_oe_n(slave_oe_n),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte),
      .tx_load(tx_load),
      .frame_start(frame_start),
      .is_read(is_read)
   );

   // open drain: drive low only
   // a one is sent by releasing the line to its pull-up
   // SDA_O is tied low; only the enable moves
   assign SDA_O = 1'b0;
   assign SDA_OE_N_O = slave_oe_n;

   // staged write burst; registers commit only after the sixth byte
   // a cut-short transfer leaves the live set untouched, so the
   // amplifier never runs on half a new configuration
   reg [7:0] stage_q [0:5];
   wire burst_done = rx_valid && (idx_q == `LAST_IDX);

   // byte index walks the fixed order, restarting each transfer
   // bytes past the sixth keep landing on the control stage
   // a read wraps to the first byte after the sixth
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         idx_q <= 3'd0;
      end else if (frame_start) begin
         idx_q <= 3'd0;
      end else if ((rx_valid || tx_load) && idx_q != `LAST_IDX) begin
         idx_q <= idx_q + 3'd1;
      end else if (tx_load) begin
         idx_q <= 3'd0; // read wraps if master keeps acking
      end
   end

   // one stage and one commit process per register
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_reg
         // staging capture of each incoming byte
         always @(posedge SYS_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               stage_q[gi] <= 8'h00;
            end else if (rx_valid && idx_q == gi) begin
               stage_q[gi] <= rx_byte;
            end
         end
         // commit whole set at once; a short burst changes nothing
         always @(posedge SYS_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               regs_q[gi] <= (gi == `IDX_MASK) ? `MASK_RESET :
                  (gi == `IDX_CTRL) ? `CTRL_RESET : `GAIN_RESET;
            end else if (burst_done) begin
               if (gi == `LAST_IDX) begin
                  regs_q[gi] <= rx_byte;
               end else begin
                  regs_q[gi] <= stage_q[gi];
               end
            end
         end
      end
   endgenerate

   // power-up sequence timer holds the busy flag
   // gains changed before the flag clears may click; the host polls it
   // the count starts again on every reset
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         busy_q <= 1'b1;
         pwrup_cnt_q <= 32'd0;
      end else if (busy_q) begin
         if (pwrup_cnt_q >= PWRUP_CYCLES - 32'd1) begin
            busy_q <= 1'b0;
         end else begin
            pwrup_cnt_q <= pwrup_cnt_q + 32'd1;
         end
      end
   end

   // tone detector: count rising edges, drop after idle time
   // a lone glitch cannot enable the tone path; a quiet spell
   // of the idle time starts the count again
   // edges are counted on the synchronised level
   reg tone_q;
   reg [3:0] edge_cnt_q;
   reg [31:0] idle_cnt_q;
   reg tone_valid_q;
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tone_q <= 1'b0;
         edge_cnt_q <= 4'h0;
         idle_cnt_q <= 32'd0;
         tone_valid_q <= 1'b0;
      end else begin
         tone_q <= tone_s;
         if (tone_s && !tone_q) begin
            idle_cnt_q <= 32'd0;
            if (edge_cnt_q < `TONE_EDGES) begin
               edge_cnt_q <= edge_cnt_q + 4'h1;
            end
            if (edge_cnt_q >= `TONE_EDGES - 4'h1) begin
               tone_valid_q <= 1'b1;
            end
         end else if (idle_cnt_q >= TONE_IDLE_CYCLES - 32'd1) begin
            edge_cnt_q <= 4'h0;
            tone_valid_q <= 1'b0;
         end else begin
            idle_cnt_q <= idle_cnt_q + 32'd1;
         end
      end
   end

   // effective mode choice: mask picks pin or control bit
   // when masked, the mode pin moves output mode, input source and
   // gain set together; the power-down pin is active low, the bit high
   // with the tone mask clear, control bit 7 forces the path on
   // tone detection still runs when that bit is clear
   wire [7:0] mask_w = regs_q[`IDX_MASK];
   wire [7:0] ctrl_w = regs_q[`IDX_CTRL];
   wire pwrdn_w = mask_w[`MASK_PWRDN] ? ~pwrdn_n_s : ctrl_w[`CTRL_PWRDN];
   wire one_ended_w = mask_w[`MASK_MODE] ? mode_pin_s : ctrl_w[`CTRL_MODE];
   wire input_w = mask_w[`MASK_MODE] ? mode_pin_s : ctrl_w[`CTRL_INPUT];
   wire gsel_w = mask_w[`MASK_MODE] ? mode_pin_s : ctrl_w[`CTRL_GSEL];
   wire tone_w = mask_w[`MASK_TONE] ? tone_valid_q :
      (ctrl_w[`CTRL_TONE] | tone_valid_q);
   wire [7:0] r_gain = gsel_w ? regs_q[`IDX_R_ONE_ENDED] : regs_q[`IDX_R_BRIDGED];
   wire [7:0] l_gain = gsel_w ? regs_q[`IDX_L_ONE_ENDED] : regs_q[`IDX_L_BRIDGED];
   wire common_mute = ctrl_w[`CTRL_MUTE] | pwrdn_w;

   // registered outputs toward the analog path, one process per group
   // so that each group can be traced on its own

   // gain codes of the active set; the mute bits never reach the code
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RIGHT_GAIN_CODE_O <= 6'h3F;
         LEFT_GAIN_CODE_O <= 6'h3F;
      end else begin
         RIGHT_GAIN_CODE_O <= r_gain[`GAIN_CODE_MSB:0];
         LEFT_GAIN_CODE_O <= l_gain[`GAIN_CODE_MSB:0];
      end
   end

   // attenuation steps; reset value matches the least-gain code
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RIGHT_ATTEN_STEP_O <= 7'h3F;
         LEFT_ATTEN_STEP_O <= 7'h3F;
      end else begin
         RIGHT_ATTEN_STEP_O <= gain_step(r_gain[`GAIN_CODE_MSB:0]);
         LEFT_ATTEN_STEP_O <= gain_step(l_gain[`GAIN_CODE_MSB:0]);
      end
   end

   // channel mutes: gain-byte bits, control mute or power-down
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         RIGHT_MUTE_O <= 1'b0;
         LEFT_MUTE_O <= 1'b0;
      end else begin
         RIGHT_MUTE_O <= gain_muted(r_gain) | common_mute;
         LEFT_MUTE_O <= gain_muted(l_gain) | common_mute;
      end
   end

   // power-down request toward the bias and output stages
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         POWER_DOWN_O <= 1'b0;
      end else begin
         POWER_DOWN_O <= pwrdn_w;
      end
   end

   // output mode and input choice, from pin or control bit
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ONE_ENDED_OUTPUT_O <= 1'b0;
         INPUT_CHOICE_BIT_O <= 1'b0;
      end else begin
         ONE_ENDED_OUTPUT_O <= one_ended_w;
         INPUT_CHOICE_BIT_O <= input_w;
      end
   end

   // tone path enable
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         TONE_ACTIVE_O <= 1'b0;
      end else begin
         TONE_ACTIVE_O <= tone_w;
      end
   end

   // power-up flag toward the host side and the analog sequencer
   always @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         POWERING_UP_O <= 1'b1;
      end else begin
         POWERING_UP_O <= busy_q;
      end
   end

   // is_read is consumed inside the slave; kept visible for the read path
   wire unused_read = is_read;
endmodule // amp_register_bank
`default_nettype wire

// >>> verification/two_wire_master.sv
// two-wire bus master model that talks to the amplifier's serial port
// assumes a 100 MHz clk; each bit takes 16 clk, a 160 ns scl period
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
   input wire logic clk,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // one bit: data moves two clk after scl falls, sampled mid-high
   task automatic bit_io(input logic v, output logic r);
      repeat (2) @(negedge clk);
      sda_o = v;
      repeat (6) @(negedge clk);
      scl_o = 1'b1;
      repeat (4) @(negedge clk);
      r = sda_i;
      repeat (4) @(negedge clk);
      scl_o = 1'b0;
   endtask
   // start from an idle bus, then hold scl low
   task automatic start();
      sda_o = 1'b0;
      repeat (8) @(negedge clk);
      scl_o = 1'b0;
   endtask
   // stop leaves both lines released high
   task automatic stop();
      repeat (2) @(negedge clk);
      sda_o = 1'b0;
      repeat (6) @(negedge clk);
      scl_o = 1'b1;
      repeat (8) @(negedge clk);
      sda_o = 1'b1;
      repeat (8) @(negedge clk);
   endtask
   // eight bits msb first, then the acknowledge bit
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack); // nack ends a read
   endtask
endmodule // two_wire_master
`default_nettype wire

// >>> verification/amp_register_bank_assertions.sv
// checker for the amplifier register bank, bound to its top ports
// assumes the power-up count is handed on by the bind
`timescale 1ns/1ps
`default_nettype none
module amp_register_bank_assertions #(
   parameter [31:0] PWRUP_CYCLES = 32'd20
) (
   input wire logic SYS_CLK_I,
   input wire logic RESETN_I,
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_N_O,
   input wire logic [5:0] RIGHT_GAIN_CODE_O,
   input wire logic [5:0] LEFT_GAIN_CODE_O,
   input wire logic [6:0] RIGHT_ATTEN_STEP_O,
   input wire logic [6:0] LEFT_ATTEN_STEP_O,
   input wire logic RIGHT_MUTE_O,
   input wire logic LEFT_MUTE_O,
   input wire logic POWER_DOWN_O,
   input wire logic TONE_ACTIVE_O,
   input wire logic POWERING_UP_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);
   logic [31:0] up_cnt_q;
   // counts edges spent in the power-up sequence
   always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         up_cnt_q <= 32'h0;
      end else if (POWERING_UP_O) begin
         up_cnt_q <= up_cnt_q + 32'h1;
      end
   end
   reset_state_a: assert property ($rose(RESETN_I) |-> SDA_OE_N_O && POWERING_UP_O &&
      RIGHT_GAIN_CODE_O == 6'h3F && LEFT_GAIN_CODE_O == 6'h3F) else $error("bad reset state");
   up_once_a: assert property (!POWERING_UP_O |=> !POWERING_UP_O)
      else $error("power-up flag rose again");
   up_len_a: assert property ($fell(POWERING_UP_O) |-> up_cnt_q >= PWRUP_CYCLES - 32'd2)
      else $error("power-up flag cleared early");
   up_bound_a: assert property (POWERING_UP_O |-> up_cnt_q <= PWRUP_CYCLES + 32'd4)
      else $error("power-up flag held too long");
   sda_move_a: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
      else $error("data line moved while clock high");
   drive_hold_a: assert property ($fell(SDA_OE_N_O) |-> !SDA_OE_N_O [*8])
      else $error("data line drive too short");
   open_drain_a: assert property (!SDA_OE_N_O |-> SDA_O == 1'b0)
      else $error("data line driven high");
   pd_mute_a: assert property (POWER_DOWN_O [*3] |-> RIGHT_MUTE_O && LEFT_MUTE_O)
      else $error("power-down without mute");
   right_step_a: assert property ($stable(RIGHT_GAIN_CODE_O) [*3] |->
      RIGHT_ATTEN_STEP_O == {1'b0, RIGHT_GAIN_CODE_O}) else $error("right step mismatch");
   left_step_a: assert property ($stable(LEFT_GAIN_CODE_O) [*3] |->
      LEFT_ATTEN_STEP_O == {1'b0, LEFT_GAIN_CODE_O}) else $error("left step mismatch");
   cover property ($fell(POWERING_UP_O));
   cover property ($rose(POWER_DOWN_O));
   cover property ($rose(TONE_ACTIVE_O));
endmodule // amp_register_bank_assertions
bind amp_register_bank amp_register_bank_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES))
   amp_register_bank_assertions_inst (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
   .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_N_O(SDA_OE_N_O),
   .RIGHT_GAIN_CODE_O(RIGHT_GAIN_CODE_O), .LEFT_GAIN_CODE_O(LEFT_GAIN_CODE_O),
   .RIGHT_ATTEN_STEP_O(RIGHT_ATTEN_STEP_O), .LEFT_ATTEN_STEP_O(LEFT_ATTEN_STEP_O),
   .RIGHT_MUTE_O(RIGHT_MUTE_O), .LEFT_MUTE_O(LEFT_MUTE_O), .POWER_DOWN_O(POWER_DOWN_O),
   .TONE_ACTIVE_O(TONE_ACTIVE_O), .POWERING_UP_O(POWERING_UP_O));
`default_nettype wire

// >>> verification/amp_register_bank_bench.sv
// self-checking bench for the amplifier register bank
// assumes the two-wire master model; sda has a pull-up
`timescale 1ns/1ps
`default_nettype none
module amp_register_bank_bench;
   logic clk, rst_n, scl, sda_m, pwrdn_n, mode_pin, tone, ack;
   logic [7:0] rx;
   wire sda_o, sda_oe_n, rm, lm, pd, oe, ich, ta, pu;
   wire [5:0] rg, lg;
   wire [6:0] rs, ls;
   wire sda_w = sda_m & (sda_oe_n | sda_o);
   int errors, checked;
   localparam logic [31:0] gains = 32'h050A4112;
   two_wire_master m (.clk(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
   amp_register_bank #(.ADDR_FIXED(5'h0C), .PWRUP_CYCLES(32'd20), .TONE_IDLE_CYCLES(32'd200))
      amp_register_bank_inst (.SYS_CLK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda_w),
      .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n), .ADDR_PIN_ONE_I(1'b1), .ADDR_PIN_ZERO_I(1'b0),
      .PWRDN_N_PIN_I(pwrdn_n), .OUTPUT_MODE_PIN_I(mode_pin), .TONE_INPUT_I(tone),
      .RIGHT_GAIN_CODE_O(rg), .LEFT_GAIN_CODE_O(lg), .RIGHT_ATTEN_STEP_O(rs),
      .LEFT_ATTEN_STEP_O(ls), .RIGHT_MUTE_O(rm), .LEFT_MUTE_O(lm), .POWER_DOWN_O(pd),
      .ONE_ENDED_OUTPUT_O(oe), .INPUT_CHOICE_BIT_O(ich), .TONE_ACTIVE_O(ta),
      .POWERING_UP_O(pu));
   // compares one value and counts the outcome
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // write burst of n bytes: four gains, mask, control
   task automatic burst(input logic [31:0] g, input logic [7:0] msk, input logic [7:0] ctl,
                        input int n);
      logic [7:0] b [6];
      b = '{g[31:24], g[23:16], g[15:8], g[7:0], msk, ctl};
      m.start();
      m.xfer(8'h64, 1'b1, rx, ack);
      check("address ack", {7'h0, ack}, 8'h00);
      foreach (b[i]) if (i < n) m.xfer(b[i], 1'b1, rx, ack);
      m.stop();
      repeat (20) @(negedge clk);
   endtask
   // read burst of all six bytes, nack on the last
   task automatic read_back(input logic [31:0] g, input logic [7:0] msk, input logic [7:0] ctl);
      logic [7:0] b [6];
      b = '{g[31:24], g[23:16], g[15:8], g[7:0], msk, ctl};
      m.start();
      m.xfer(8'h65, 1'b1, rx, ack);
      foreach (b[i]) begin
         m.xfer(8'hFF, i == 5, rx, ack);
         check("read byte", rx, b[i]);
      end
      m.stop();
   endtask
   // flags are right mute, left mute, power-down, one-ended, input, tone
   task automatic expect_out(input logic [5:0] r, input logic [5:0] l, input logic [5:0] f);
      repeat (10) @(negedge clk);
      check("right code", {2'b0, rg}, {2'b0, r});
      check("left code", {2'b0, lg}, {2'b0, l});
      check("right step", {1'b0, rs}, {2'b0, r});
      check("left step", {1'b0, ls}, {2'b0, l});
      check("flags", {2'b0, rm, lm, pd, oe, ich, ta}, {2'b0, f});
   endtask
   task automatic t_reset();
      expect_out(6'h3F, 6'h3F, 6'b000000);
      check("powering up", {7'h0, pu}, 8'h01);
      for (int k = 0; k < 100 && pu !== 1'b0; k++) @(negedge clk);
      check("powered up", {7'h0, pu}, 8'h00);
      read_back(32'h3F3F3F3F, 8'h7F, 8'h00);
      $display("reset test done");
   endtask
   task automatic t_register();
      pwrdn_n = 1'b0;
      burst(gains, 8'h00, 8'h72, 6);
      expect_out(6'h01, 6'h12, 6'b100110);
      read_back(gains, 8'h00, 8'h72);
      burst(gains, 8'h00, 8'h99, 6);
      expect_out(6'h05, 6'h0A, 6'b111001);
      $display("register control test done");
   endtask
   task automatic t_pins();
      pwrdn_n = 1'b1;
      mode_pin = 1'b1;
      burst(gains, 8'hFF, 8'h10, 6);
      expect_out(6'h01, 6'h12, 6'b100110);
      read_back(gains, 8'h7F, 8'h10);
      mode_pin = 1'b0;
      expect_out(6'h05, 6'h0A, 6'b000000);
      pwrdn_n = 1'b0;
      expect_out(6'h05, 6'h0A, 6'b111000);
      $display("pin control test done");
   endtask
   task automatic t_refused();
      burst(32'h00000000, 8'h00, 8'h10, 5);
      expect_out(6'h05, 6'h0A, 6'b111000);
      m.start();
      m.xfer(8'h62, 1'b1, rx, ack);
      m.stop();
      check("foreign address ack", {7'h0, ack}, 8'h01);
      $display("refusal test done");
   endtask
   task automatic t_tone();
      pwrdn_n = 1'b1;
      for (int k = 0; k < 8; k++) begin
         expect_out(6'h05, 6'h0A, 6'b000000);
         tone = 1'b1;
         repeat (4) @(negedge clk);
         tone = 1'b0;
      end
      expect_out(6'h05, 6'h0A, 6'b000001);
      $display("tone test done");
   endtask
   // clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog cuts a hang short
   initial begin
      #300us;
      errors++;
      final_report();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      m.sda_o = 1'b1;
      pwrdn_n = 1'b1;
      mode_pin = 1'b0;
      tone = 1'b0;
      m.scl_o = 1'b1;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_register();
      t_pins();
      t_refused();
      t_tone();
      final_report();
   end
endmodule // amp_register_bank_bench
`default_nettype wire
